// ===== common/sbl_cfg.svh
// Constants for the serial boot loader
`ifndef SBL_CFG_SVH
`define SBL_CFG_SVH
`define SBL_ACK        8'hCC
`define SBL_NAK        8'h33
`define SBL_CMD_PING   8'h20
`define SBL_CMD_LOAD   8'h21
`define SBL_CMD_RUN    8'h22
`define SBL_CMD_STAT   8'h23
`define SBL_CMD_DATA   8'h24
`define SBL_CMD_RST    8'h25
`define SBL_ST_OK      8'h40
`define SBL_ST_UNK     8'h41
`define SBL_ST_BAD     8'h42
`define SBL_ST_FLASH   8'h43
`define SBL_LEN_MIN    8'h03
`define SBL_LEN_LOAD   8'h0B
`define SBL_LEN_RUN    8'h07
`define SBL_HDR_BYTES  8'h02
`define SBL_RSP_LEN    8'h03
`define SBL_PAY_TOP    4'h8
`define SBL_PKT_LAST   2'h2
`define SBL_AB_FALLS   4'h7
`define SBL_AB_TAIL    4'h8
`define SBL_AB_SHIFT   4
`define SBL_AB_MIN     12'h020
`define SBL_AB_W       16
`define SBL_PER_W      12
`define SBL_BIT_STOP   4'h9
`define SBL_FRAME_BITS 4'hA
`define SBL_BIT_LAST   3'h7
`endif

// ===== common/sbl_pkg.sv
// Types shared by the serial boot loader files
package sbl_pkg;
    typedef enum logic [1:0] {
        sel_none = 2'h0,
        sel_uart = 2'h1,
        sel_spi  = 2'h3
    } sbl_sel_t;
    typedef enum logic [3:0] {
        st_wait_len  = 4'h0,
        st_get_sum   = 4'h1,
        st_get_data  = 4'h3,
        st_check     = 4'h2,
        st_flash     = 4'h6,
        st_send_ans  = 4'h7,
        st_after_ans = 4'h5,
        st_send_pkt  = 4'h4,
        st_wait_resp = 4'hC
    } sbl_state_t;
    typedef enum logic [1:0] {
        ab_idle = 2'h0,
        ab_meas = 2'h1,
        ab_tail = 2'h3
    } sbl_ab_t;
    typedef enum logic [1:0] {
        fl_none  = 2'h0,
        fl_erase = 2'h1,
        fl_write = 2'h3
    } sbl_fl_op_t;
    typedef struct packed {
        logic        req;
        sbl_fl_op_t  op;
        logic [31:0] addr;
        logic [31:0] len;
        logic [7:0]  data;
    } sbl_flash_t;
    typedef struct packed {
        logic       stb;
        logic [7:0] data;
    } sbl_byte_t;
endpackage

// ===== verilog/sbl_uart.sv
// Asynchronous 8N1 receiver and transmitter at a programmed bit period
`timescale 1ns/100ps
`default_nettype none
`include "sbl_cfg.svh"
module sbl_uart (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  enable,
    input  wire logic [`SBL_PER_W-1:0] period,
    input  wire logic                  rxd_s,
    input  wire logic                  tx_valid,
    input  wire logic [7:0]            tx_data,
    output logic                       tx_busy,
    output logic                       txd,
    output var sbl_pkg::sbl_byte_t     rx
);
    logic                  rx_act;
    logic [`SBL_PER_W-1:0] rx_tmr;
    logic [3:0]            rx_bit;
    logic [7:0]            rx_sh;
    logic [`SBL_PER_W-1:0] tx_tmr;
    logic [9:0]            tx_sh;
    logic [3:0]            tx_left;
    wire rx_tick = rx_tmr == '0;
    wire tx_tick = tx_tmr == '0;
    wire rx_stop = rx_act && rx_tick && rx_bit == `SBL_BIT_STOP;
    assign tx_busy = tx_left != 4'h0;
    assign txd     = tx_sh[0];
    // Mid-bit sampling; a glitch that fails the start check is dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_act <= 1'b0;
            rx_tmr <= '0;
            rx_bit <= 4'h0;
            rx_sh  <= 8'h00;
        end else if (!enable) begin
            rx_act <= 1'b0;
        end else if (!rx_act) begin
            rx_act <= !rxd_s;
            rx_tmr <= period >> 1;
            rx_bit <= 4'h0;
        end else if (!rx_tick) begin
            rx_tmr <= rx_tmr - 1'b1;
        end else begin
            rx_tmr <= period - 1'b1;
            rx_bit <= rx_bit + 4'h1;
            if (!rx_stop)
                rx_sh <= {rxd_s, rx_sh[7:1]};
            if ((rx_bit == 4'h0 && rxd_s) || rx_stop)
                rx_act <= 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx <= '0;
        end else begin
            rx.stb  <= enable && rx_stop && rxd_s;
            rx.data <= rx_sh;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh   <= '1;
            tx_left <= 4'h0;
            tx_tmr  <= '0;
        end else if (tx_valid && !tx_busy) begin
            tx_sh   <= {1'b1, tx_data, 1'b0};
            tx_left <= `SBL_FRAME_BITS;
            tx_tmr  <= period - 1'b1;
        end else if (tx_busy && tx_tick) begin
            tx_sh   <= {1'b1, tx_sh[9:1]};
            tx_left <= tx_left - 4'h1;
            tx_tmr  <= period - 1'b1;
        end else if (tx_busy) begin
            tx_tmr  <= tx_tmr - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sbl_spi.sv
// Synchronous serial slave, mode with idle-high clock, second-edge capture
`timescale 1ns/100ps
`default_nettype none
`include "sbl_cfg.svh"
module sbl_spi (
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       rst_n,
    input  wire logic       mosi,
    output logic            miso,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_req,
    output logic            tx_ack,
    output logic [7:0]      rx_data,
    output logic            rx_tgl
);
    logic [2:0] bitcnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic       req_m;
    logic       req_s;
    wire frame_rst_n = rst_n && !cs_n;
    wire byte_end = bitcnt == `SBL_BIT_LAST;
    assign miso = sh_out[7];
    // Bit count dies with the frame, so a cut frame cannot skew bytes
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bitcnt <= 3'h0;
            sh_in  <= 8'h00;
        end else begin
            bitcnt <= bitcnt + 3'h1;
            sh_in  <= {sh_in[6:0], mosi};
        end
    end
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= 8'h00;
            rx_tgl  <= 1'b0;
        end else if (!cs_n && byte_end) begin
            rx_data <= {sh_in[6:0], mosi};
            rx_tgl  <= !rx_tgl;
        end
    end
    // No word pending at a byte boundary means a zero pad goes out
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            req_m  <= 1'b0;
            req_s  <= 1'b0;
            tx_ack <= 1'b0;
            sh_out <= 8'h00;
        end else begin
            req_m <= tx_req;
            req_s <= req_m;
            if (bitcnt != 3'h0) begin
                sh_out <= {sh_out[6:0], 1'b0};
            end else if (req_s != tx_ack) begin
                sh_out <= tx_byte;
                tx_ack <= !tx_ack;
            end else begin
                sh_out <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sbl_loader.sv
// Serial boot loader: port lock, auto-baud, packets and commands
`timescale 1ns/100ps
`default_nettype none
`include "sbl_cfg.svh"
module sbl_loader (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            uart_rxd,
    output logic                 uart_txd,
    input  wire logic            spi_sclk,
    input  wire logic            spi_cs_n,
    input  wire logic            spi_mosi,
    output logic                 spi_miso,
    output logic                 spi_miso_oe_n,
    output var sbl_pkg::sbl_flash_t flash,
    input  wire logic            flash_done,
    input  wire logic            flash_err,
    output logic                 run_req,
    output logic [31:0]          run_addr,
    output logic                 reset_req,
    output var sbl_pkg::sbl_sel_t port_sel
);
    sbl_pkg::sbl_state_t   state;
    sbl_pkg::sbl_state_t   next_state;
    sbl_pkg::sbl_ab_t      ab;
    sbl_pkg::sbl_byte_t    urx;
    logic                  rxd_m;
    logic                  rxd_s;
    logic                  rxd_d;
    logic                  rtg;
    logic                  rtg_m;
    logic                  rtg_s;
    logic                  rtg_d;
    logic                  ack;
    logic                  ack_m;
    logic                  ack_s;
    logic                  spi_req;
    logic [7:0]            spi_rx;
    logic                  u_busy;
    logic [`SBL_AB_W-1:0]  ab_cnt;
    logic [3:0]            ab_falls;
    logic [`SBL_PER_W-1:0] period;
    logic                  tx_go;
    logic [7:0]            tx_byte;
    logic [1:0]            pkt_idx;
    logic [7:0]            len;
    logic [7:0]            remain;
    logic [7:0]            rx_sum;
    logic [7:0]            sum_acc;
    logic [3:0]            idx;
    logic                  ovf;
    logic [7:0]            ans;
    logic [7:0]            status;
    logic [31:0]           prog_addr;
    logic [31:0]           prog_left;
    logic [3:0]            fl_idx;
    wire  [8:0][7:0]       pay;

    // The UART pin and the cross-domain toggles pass two flops before use; spi_rx is read unsynced once its toggle is seen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
            rxd_d <= 1'b1;
        end else begin
            rxd_m <= uart_rxd;
            rxd_s <= rxd_m;
            rxd_d <= rxd_s;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rtg_m <= 1'b0;
            rtg_s <= 1'b0;
            rtg_d <= 1'b0;
            ack_m <= 1'b0;
            ack_s <= 1'b0;
        end else begin
            rtg_m <= rtg;
            rtg_s <= rtg_m;
            rtg_d <= rtg_s;
            ack_m <= ack;
            ack_s <= ack_m;
        end
    end

    wire rxd_fall  = rxd_d && !rxd_s;
    wire spi_stb   = rtg_s ^ rtg_d;
    wire spi_busy  = spi_req ^ ack_s;
    wire sel_idle  = port_sel == sbl_pkg::sel_none;
    wire uart_on   = port_sel == sbl_pkg::sel_uart;
    wire spi_on    = port_sel == sbl_pkg::sel_spi;

    // Auto-baud: nine falls of two 0x55 bytes span sixteen bit times
    wire [`SBL_PER_W-1:0] ab_per = ab_cnt[`SBL_AB_W-1:`SBL_AB_SHIFT];
    wire ab_ovf = &ab_cnt;
    wire ab_hit = rxd_fall && ab_falls == `SBL_AB_FALLS;
    wire ab_ok  = ab_per >= `SBL_AB_MIN;
    // Tenth fall must pass, or its data bit would look like a start bit
    wire ab_end = ab == sbl_pkg::ab_tail && rxd_s && sel_idle
                  && ab_falls == `SBL_AB_TAIL;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ab       <= sbl_pkg::ab_idle;
            ab_cnt   <= '0;
            ab_falls <= 4'h0;
            period   <= '0;
        end else begin
            unique case (ab)
                sbl_pkg::ab_idle: if (rxd_fall && sel_idle) begin
                    ab       <= sbl_pkg::ab_meas;
                    ab_cnt   <= {{(`SBL_AB_W-1){1'b0}}, 1'b1};
                    ab_falls <= 4'h0;
                end
                sbl_pkg::ab_meas: begin
                    ab_cnt <= ab_cnt + 1'b1;
                    if (!sel_idle || ab_ovf) begin
                        ab <= sbl_pkg::ab_idle;
                    end else if (ab_hit) begin
                        period <= ab_per;
                        ab     <= ab_ok ? sbl_pkg::ab_tail
                                        : sbl_pkg::ab_idle;
                    end else if (rxd_fall) begin
                        ab_falls <= ab_falls + 4'h1;
                    end
                end
                sbl_pkg::ab_tail: begin
                    ab_cnt <= ab_cnt + 1'b1;
                    if (ab_end || !sel_idle || ab_ovf)
                        ab <= sbl_pkg::ab_idle;
                    else if (rxd_fall)
                        ab_falls <= ab_falls + 4'h1;
                end
                default: ab <= sbl_pkg::ab_idle;
            endcase
        end
    end

    // Once locked, only a reset frees the port choice
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            port_sel <= sbl_pkg::sel_none;
        else if (sel_idle && ab_end)
            port_sel <= sbl_pkg::sel_uart;
        else if (sel_idle && spi_stb)
            port_sel <= sbl_pkg::sel_spi;
    end

    // One byte stream from whichever port owns the session
    wire       spi_take = spi_stb && (spi_on || (sel_idle && !ab_end));
    wire       in_stb   = uart_on ? urx.stb : spi_take;
    wire [7:0] in_data  = uart_on ? urx.data : spi_rx;
    wire       in_nz    = in_stb && in_data != 8'h00;
    wire       tx_busy  = tx_go || (uart_on ? u_busy : spi_busy);

    // Packet decode
    wire [7:0]  cmd      = pay[0];
    wire        short_in = in_data < `SBL_LEN_MIN;
    wire        sum_ok   = sum_acc == rx_sum && !ovf;
    wire        is_load  = cmd == `SBL_CMD_LOAD && len == `SBL_LEN_LOAD;
    wire        is_run   = cmd == `SBL_CMD_RUN && len == `SBL_LEN_RUN;
    wire        is_data  = cmd == `SBL_CMD_DATA;
    wire [31:0] word1    = {pay[1], pay[2], pay[3], pay[4]};
    wire [31:0] word2    = {pay[5], pay[6], pay[7], pay[8]};
    wire        go_flash = sum_ok && (is_load || is_data);
    wire        more_wr  = flash.op == sbl_pkg::fl_write
                           && fl_idx < idx && prog_left != '0;
    wire        acked    = ans == `SBL_ACK;
    wire        want_pkt = acked && cmd == `SBL_CMD_STAT;
    wire        in_chk   = state == sbl_pkg::st_check;
    wire        in_fl    = state == sbl_pkg::st_flash;
    wire        post     = state == sbl_pkg::st_after_ans && !tx_busy;
    wire        pay_we   = state == sbl_pkg::st_get_data && in_stb;
    wire        fsm_send = !tx_busy
                           && (state == sbl_pkg::st_send_ans
                               || state == sbl_pkg::st_send_pkt);
    wire [7:0]  pkt_byte = pkt_idx == 2'h0 ? `SBL_RSP_LEN : status;
    wire [7:0]  fsm_byte = state == sbl_pkg::st_send_ans ? ans : pkt_byte;

    always_comb begin
        next_state = state;
        unique case (state)
            sbl_pkg::st_wait_len: if (in_nz)
                next_state = short_in ? sbl_pkg::st_send_ans
                                      : sbl_pkg::st_get_sum;
            sbl_pkg::st_get_sum: if (in_stb)
                next_state = sbl_pkg::st_get_data;
            sbl_pkg::st_get_data: if (in_stb && remain == 8'h01)
                next_state = sbl_pkg::st_check;
            sbl_pkg::st_check:
                next_state = go_flash ? sbl_pkg::st_flash
                                      : sbl_pkg::st_send_ans;
            sbl_pkg::st_flash: if (!flash.req && !more_wr)
                next_state = sbl_pkg::st_send_ans;
            sbl_pkg::st_send_ans: if (!tx_busy)
                next_state = sbl_pkg::st_after_ans;
            sbl_pkg::st_after_ans: if (!tx_busy)
                next_state = want_pkt ? sbl_pkg::st_send_pkt
                                      : sbl_pkg::st_wait_len;
            sbl_pkg::st_send_pkt: if (fsm_send && pkt_idx == `SBL_PKT_LAST)
                next_state = sbl_pkg::st_wait_resp;
            sbl_pkg::st_wait_resp: if (in_nz)
                next_state = sbl_pkg::st_wait_len;
            default: next_state = sbl_pkg::st_wait_len;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            state <= sbl_pkg::st_wait_len;
        else
            state <= next_state;
    end

    // Framing: length, checksum, payload; extra bytes only flag overflow
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            len     <= 8'h00;
            remain  <= 8'h00;
            rx_sum  <= 8'h00;
            sum_acc <= 8'h00;
            idx     <= 4'h0;
            ovf     <= 1'b0;
        end else if (state == sbl_pkg::st_wait_len && in_nz) begin
            len     <= in_data;
            remain  <= in_data - `SBL_HDR_BYTES;
            sum_acc <= 8'h00;
            idx     <= 4'h0;
            ovf     <= 1'b0;
        end else if (state == sbl_pkg::st_get_sum && in_stb) begin
            rx_sum  <= in_data;
        end else if (pay_we) begin
            sum_acc <= sum_acc + in_data;
            remain  <= remain - 8'h01;
            if (idx > `SBL_PAY_TOP)
                ovf <= 1'b1;
            else
                idx <= idx + 4'h1;
        end
    end

    generate
        for (genvar i = 0; i <= `SBL_PAY_TOP; i++) begin : g_pay
            logic [7:0] q;
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n)
                    q <= 8'h00;
                else if (pay_we && idx == 4'(i))
                    q <= in_data;
            end
            assign pay[i] = q;
        end
    endgenerate

    // Command execution; the answer byte depends on framing alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ans       <= `SBL_NAK;
            status    <= `SBL_ST_OK;
            prog_addr <= '0;
            prog_left <= '0;
            fl_idx    <= 4'h0;
            run_addr  <= '0;
            flash     <= '0;
        end else if (state == sbl_pkg::st_wait_len && in_nz && short_in) begin
            ans <= `SBL_NAK;
        end else if (in_chk) begin
            ans <= sum_ok ? `SBL_ACK : `SBL_NAK;
            if (!sum_ok) begin
                status <= status;
            end else if (cmd == `SBL_CMD_PING) begin
                status <= `SBL_ST_OK;
            end else if (is_load) begin
                prog_addr <= word1;
                prog_left <= word2;
                flash     <= {1'b1, sbl_pkg::fl_erase, word1, word2, 8'h00};
                status    <= `SBL_ST_OK;
            end else if (is_data) begin
                fl_idx   <= 4'h1;
                flash.op <= sbl_pkg::fl_write;
                status   <= prog_left == '0 ? `SBL_ST_BAD : `SBL_ST_OK;
            end else if (is_run) begin
                run_addr <= word1;
                status   <= `SBL_ST_OK;
            end else if (cmd == `SBL_CMD_RST) begin
                status <= `SBL_ST_OK;
            end else if (cmd != `SBL_CMD_STAT) begin
                status <= cmd == `SBL_CMD_LOAD || cmd == `SBL_CMD_RUN
                          ? `SBL_ST_BAD : `SBL_ST_UNK;
            end
        end else if (in_fl && flash.req && flash_done) begin
            flash.req <= 1'b0;
            if (flash_err)
                status <= `SBL_ST_FLASH;
            if (flash.op == sbl_pkg::fl_write) begin
                prog_addr <= prog_addr + 32'h1;
                prog_left <= prog_left - 32'h1;
                fl_idx    <= fl_idx + 4'h1;
            end
        end else if (in_fl && !flash.req && more_wr) begin
            flash <= {1'b1, sbl_pkg::fl_write, prog_addr, 32'h1,
                      pay[fl_idx]};
        end
    end

    // Run and reset only fire once the acknowledge has left the UART, or for SPI once the slave has loaded it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_req   <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            run_req   <= post && acked && is_run;
            reset_req <= post && acked && cmd == `SBL_CMD_RST;
        end
    end

    // Outgoing bytes; the SPI word is held until its toggle returns
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_go   <= 1'b0;
            tx_byte <= 8'h00;
            pkt_idx <= 2'h0;
            spi_req <= 1'b0;
        end else begin
            tx_go   <= fsm_send || ab_end;
            spi_req <= spi_req ^ (tx_go && spi_on);
            if (ab_end)
                tx_byte <= `SBL_ACK;
            else if (fsm_send)
                tx_byte <= fsm_byte;
            if (state == sbl_pkg::st_after_ans)
                pkt_idx <= 2'h0;
            else if (fsm_send && state == sbl_pkg::st_send_pkt)
                pkt_idx <= pkt_idx + 2'h1;
        end
    end

    assign spi_miso_oe_n = spi_cs_n || !spi_on;

    sbl_uart u_uart (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (uart_on),
        .period   (period),
        .rxd_s    (rxd_s),
        .tx_valid (tx_go && uart_on),
        .tx_data  (tx_byte),
        .tx_busy  (u_busy),
        .txd      (uart_txd),
        .rx       (urx)
    );

    sbl_spi u_spi (
        .sclk    (spi_sclk),
        .cs_n    (spi_cs_n),
        .rst_n   (rst_n),
        .mosi    (spi_mosi),
        .miso    (spi_miso),
        .tx_byte (tx_byte),
        .tx_req  (spi_req),
        .tx_ack  (ack),
        .rx_data (spi_rx),
        .rx_tgl  (rtg)
    );
endmodule
`default_nettype wire

// ===== testbench/sbl_loader_chk.sv
// Port checker for the serial boot loader
`timescale 1ns/100ps
`default_nettype none
module sbl_loader_chk (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                uart_txd,
    input wire logic                spi_cs_n,
    input wire logic                spi_miso_oe_n,
    input wire sbl_pkg::sbl_flash_t flash,
    input wire logic                flash_done,
    input wire logic                run_req,
    input wire sbl_pkg::sbl_sel_t   port_sel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence lock_uart;
        port_sel == sbl_pkg::sel_none ##1 port_sel == sbl_pkg::sel_uart;
    endsequence
    chk_sel_sticky: assert property (port_sel != 0 |=> $stable(port_sel))
        else $error("port lock lost");
    chk_sync_reply: assert property (lock_uart |-> ##[0:4] !uart_txd)
        else $error("no sync reply");
    chk_idle_high: assert property (port_sel == 0 |-> uart_txd)
        else $error("tx before lock");
    chk_oe_follow: assert property (spi_miso_oe_n ==
        (spi_cs_n || port_sel != sbl_pkg::sel_spi)) else $error("miso enable");
    chk_run_pulse: assert property (run_req |=> !run_req)
        else $error("run pulse long");
    chk_run_after: assert property (run_req |-> uart_txd && $past(uart_txd))
        else $error("run before ack");
    chk_flash_hold: assert property (flash.req && !flash_done
        |=> flash.req && $stable(flash.addr)) else $error("flash req");
    chk_flash_op: assert property (flash.req |-> flash.op == 2'h1
        || (flash.op == 2'h3 && flash.len == 32'h1)) else $error("flash op");
endmodule
bind sbl_loader sbl_loader_chk chk (.mclk, .rst_n, .uart_txd, .spi_cs_n,
    .spi_miso_oe_n, .flash, .flash_done, .run_req, .port_sel);
`default_nettype wire

// ===== testbench/sbl_host.sv
// Host model: async serial master for the boot loader
`timescale 1ns/100ps
`default_nettype none
module sbl_host #(parameter int BIT = 40) (
    input wire logic mclk,
    input wire logic rxd,
    output logic     txd
);
    logic [7:0] got[$];
    logic [7:0] sh;
    logic [9:0] f;
    initial txd = 1'b1;
    task automatic put(input logic [7:0] b);
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            txd <= f[i];
            repeat (BIT) @(posedge mclk);
        end
    endtask
    // Free-running so an answer racing our stop bit is not lost
    always begin
        @(negedge rxd);
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk);
            sh[i] = rxd;
        end
        repeat (BIT) @(posedge mclk);
        got.push_back(sh);
    end
endmodule
`default_nettype wire

// ===== testbench/sbl_loader_bench.sv
// Bench for the serial boot loader
`timescale 1ns/100ps
`default_nettype none
module sbl_loader_bench;
    logic                mclk, rst_n, sclk, cs_n, mosi, done, run_req;
    logic                txd_h, txd_d, miso, oe_n, rreq, rq;
    logic [31:0]         run_addr, ran;
    logic [31:0]         wa[$];
    logic [7:0]          wd[$];
    sbl_pkg::sbl_flash_t flash;
    sbl_pkg::sbl_sel_t   port_sel;
    int                  num_errors, comparisons;
    sbl_loader dut (.mclk, .rst_n, .uart_rxd(txd_h), .uart_txd(txd_d),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe_n(oe_n), .flash, .flash_done(done), .flash_err(1'b0),
        .run_req, .run_addr, .reset_req(rreq), .port_sel);
    sbl_host host (.mclk, .rxd(txd_d), .txd(txd_h));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        done <= flash.req && !done;
        if (flash.req && !done) begin
            wa.push_back(flash.addr);
            wd.push_back(flash.data);
        end
        if (run_req) ran <= run_addr;
        if (rreq) rq <= 1'b1;
    end
    localparam int SPI_HALF = 120;
    // Host side of one sync-port byte, idle-high clock
    task automatic sx(input logic [7:0] o, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            #SPI_HALF sclk = 1'b0;
            mosi = o[i];
            #SPI_HALF sclk = 1'b1;
            r[i] = miso;
        end
    endtask
    task automatic stop_test;
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic pkt(input logic [7:0] b[$]);
        foreach (b[i]) host.put(b[i]);
    endtask
    task automatic xa(input logic [7:0] e, input string n);
        logic [7:0] b;
        int t;
        t = 0;
        b = 8'h00;
        while (b === 8'h00) begin
            while (host.got.size() == 0 && t < 20000) begin
                @(posedge mclk);
                t++;
            end
            if (t >= 20000) begin
                num_errors++;
                stop_test();
            end
            b = host.got.pop_front();
        end
        chk(n, b, e);
    endtask
    task automatic q(input logic [7:0] e);
        pkt('{8'h03, 8'h23, 8'h23});
        xa(8'hCC, "qack");
        xa(8'h03, "qlen");
        xa(e, "qsum");
        xa(e, "qst");
        host.put(8'hCC);
    endtask
    task automatic t_ping;
        for (int n = 0; n < 2 && host.got.size() == 0; n++) begin
            pkt('{8'h55, 8'h55});
            for (int t = 0; t < 40 * host.BIT && host.got.size() == 0; t++)
                @(posedge mclk);
        end
        xa(8'hCC, "sync");
        pkt('{8'h03, 8'h20, 8'h20});
        xa(8'hCC, "ping");
        pkt('{8'h03, 8'h21, 8'h20});
        xa(8'h33, "bad");
        pkt('{8'h00, 8'h03, 8'h26, 8'h26});
        xa(8'hCC, "unk");
        q(8'h41);
    endtask
    task automatic t_load;
        pkt('{8'h0B, 8'h34, 8'h21, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00,
              8'h00, 8'h03});
        xa(8'hCC, "load");
        pkt('{8'h05, 8'h23, 8'h24, 8'hAA, 8'h55});
        xa(8'hCC, "d1");
        pkt('{8'h04, 8'h00, 8'h24, 8'h66});
        xa(8'h33, "dnak");
        pkt('{8'h04, 8'h9B, 8'h24, 8'h77});
        xa(8'hCC, "d2");
        q(8'h40);
        chk("nw", wa.size(), 4);
        chk("era", wa[0], 32'h1000);
        chk("a2", wa[3], 32'h1002);
        chk("d", {wd[1], wd[2], wd[3]}, 24'hAA5577);
    endtask
    task automatic t_spi;
        logic [7:0] r;
        cs_n <= 1'b0;
        sx(8'h55, r);
        chk("oeu", oe_n, 1'b1);
        chk("mlk", r, 8'h00);
        #SPI_HALF cs_n = 1'b1;
        repeat (10) @(posedge mclk);
        chk("lock", port_sel, sbl_pkg::sel_uart);
    endtask
    task automatic t_sess;
        logic [7:0] r;
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        cs_n <= 1'b0;
        sx(8'h03, r);
        sx(8'h20, r);
        sx(8'h20, r);
        chk("oes", oe_n, 1'b0);
        r = 8'h00;
        for (int n = 0; n < 8 && r == 8'h00; n++)
            sx(8'h00, r);
        chk("sack", r, 8'hCC);
        #SPI_HALF cs_n = 1'b1;
        chk("slock", port_sel, sbl_pkg::sel_spi);
    endtask
    task automatic t_run;
        int t;
        pkt('{8'h03, 8'h25, 8'h25});
        xa(8'hCC, "rack");
        pkt('{8'h07, 8'h42, 8'h22, 8'h00, 8'h00, 8'h20, 8'h00});
        xa(8'hCC, "run");
        for (t = 0; t < 500 && ran !== 32'h2000; t++) @(posedge mclk);
        chk("radr", ran, 32'h2000);
        chk("rreq", rq, 1'b1);
    endtask
    initial begin
        {rst_n, mosi, done, rq, ran, num_errors, comparisons} = '0;
        {sclk, cs_n} = 2'b11;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("idle", {txd_d, port_sel, flash.req}, 4'h8);
        t_ping();
        t_load();
        t_spi();
        t_run();
        t_sess();
        stop_test();
    end
endmodule
`default_nettype wire
